// [hdl/can_ctl_pkg.sv]
// Constants for the CAN control, bit-timing and interrupt-flag block
// Overview of operation
// - Stop-in-idle set: timing engine freezes while system is idle
// - Busy status reads 1 while active, 0 only when fully disabled
// - Five-bit data compare count; 0 disables, 18 maximum, 19-31 invalid
// - Wake line filter enable routes bus activity through a filter for wake-up
// - Propagation, phase one, phase two fields: value plus one quanta
// - Phase two select: programmed length, else max of phase one and processing time
// - Automatic phase two (select clear) is never shorter than phase one
// - Triple sample enable: three samples at sample point, else one
// - Jump width is value plus one quanta, kept within phase two; the logic does not clamp it to phase two
// - Time quantum is two times (prescaler plus one) bus clocks
// - Timing register writes land only in configuration mode, code 100
// - Nine read/write interrupt enable bits in the upper half
// - Invalid message received sets its flag
// - System bus error sets the system error flag
// - System error flag ignores writes; cleared only by re-enabling the module
// - Mode change flag set when reported mode reaches requested mode
// - Timestamp timer overflow sets its flag
// - Wake activity, bus error, receive overflow each set their flag
// - Receive and transmit buffer flags follow pending requests
// - Mode codes: 000 normal, 001 disable, 010 loop, 011 listen, 100 config, 111 all
package can_ctl_pkg;
  // ********************
  // Register map
  // ********************
  localparam logic [7:0] OFS_CON = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_INT = 8'h20;
  // Control register fields
  localparam int DNC_LSB   = 0;
  localparam int BUSY_BIT  = 11;
  localparam int STOP_IN_IDLE_BIT = 13;
  localparam int ON_BIT    = 15;
  localparam int OPM_LSB   = 21;
  localparam int REQ_LSB   = 24;
  localparam logic [4:0] DNC_MAX = 5'h12;
  // Timing register fields
  localparam int BRP_LSB   = 0;
  localparam int SJW_LSB   = 6;
  localparam int PROP_LSB  = 8;
  localparam int PH1_LSB   = 11;
  localparam int SAM_BIT   = 14;
  localparam int PH2TS_BIT = 15;
  localparam int PH2_LSB   = 16;
  localparam int WFIL_BIT  = 22;
  localparam logic [31:0] CFG_MASK = 32'h0047_ffff;
  // Interrupt register fields
  localparam int IE_HI_LSB = 27;
  localparam int IE_LO_LSB = 16;
  localparam int IF_HI_LSB = 11;
  localparam int IF_LO_LSB = 0;
  // ********************
  // Operating modes
  // ********************
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_DISABLE = 3'h1;
  localparam logic [2:0] MODE_LOOP = 3'h2;
  localparam logic [2:0] MODE_LISTEN = 3'h3;
  localparam logic [2:0] MODE_CONFIG = 3'h4;
  localparam logic [2:0] MODE_ALL = 3'h7;
  localparam logic [2:0] MODE_RESET = MODE_CONFIG;
  // ********************
  // Timing
  // ********************
  localparam int CLK_NS        = 20;
  localparam int WAKE_FILT_NS  = 200;
  localparam int WAKE_FILT_CYC = (WAKE_FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] IPT_CODE = 3'h1;  // Processing time, two quanta
endpackage : can_ctl_pkg

// [hdl/can_control_timing_irq.sv]
// CAN control, bit-timing engine and interrupt flags behind a Wishbone slave
`timescale 1ns/10ps
module can_control_timing_irq
  import can_ctl_pkg::*;
#(
  parameter int FILT_CYC = WAKE_FILT_CYC
)
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_can_rx,
  input  wire logic        i_sys_idle,
  input  wire logic        i_txn_active,
  input  wire logic        i_invalid_msg,
  input  wire logic        i_bus_error,
  input  wire logic        i_system_error,
  input  wire logic        i_rx_overflow,
  input  wire logic        i_timer_overflow,
  input  wire logic        i_rx_buffer_pending,
  input  wire logic        i_tx_buffer_pending,
  output logic             o_irq,
  output logic             o_tq_tick,
  output logic             o_sample_point,
  output logic             o_sample_bit,
  output logic             o_halted,
  output logic      [4:0]  o_data_compare_count
);

  // Filter counter is 8 bits wide
  if (FILT_CYC < 1 || FILT_CYC > 255)
  begin : g_bad_filt
    $error("FILT_CYC out of range");
  end

  // ********************
  // Declarations
  // ********************
  logic        ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic        on_ff, nxt_on, stop_in_idle_ff, nxt_stop_in_idle, busy_ff, nxt_busy;
  logic [4:0]  dnc_ff, nxt_dnc;
  logic [2:0]  req_ff, nxt_req, opm_ff, nxt_opm;
  logic [31:0] cfg_ff, nxt_cfg;
  logic [8:0]  ien_ff, nxt_ien;
  logic [6:0]  flg_ff, nxt_flg;
  logic        irq_ff, nxt_irq;
  logic        wr, rd_hit;
  logic [31:0] wmask, wcon, wcfg, wint;
  logic [31:0] mcon, mint;
  logic        re_enable;
  logic [8:0]  flags_all;
  // Timing engine
  logic [6:0]  pcnt_ff, nxt_pcnt;
  logic [4:0]  q_ff, nxt_q;
  logic [2:0]  ext_ff, nxt_ext;
  logic [2:0]  smp_ff, nxt_smp;
  logic        rxp_ff, nxt_rxp;
  logic        tick_ff, spt_ff, sbit_ff, halt_ff;
  logic        run, tick, spt, sbit;
  logic [2:0]  ph2_code;
  logic [4:0]  prop_q, ph1_q, ph2_q, sjw_q, sp_q, bit_q;
  // Wake filter
  logic [7:0]  fcnt_ff, nxt_fcnt;
  logic        frx_ff, nxt_frx, wrx_ff, nxt_wrx;
  logic        wake_ev, wrx_now;

  // ********************
  // Wishbone slave
  // ********************
  // Single-cycle-wait ack; unmapped offsets ack with zero data
  always_comb
  begin
    wr        = i_wb_cyc && i_wb_stb && !ack_ff && i_wb_we;
    wmask     = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    nxt_ack   = i_wb_cyc && i_wb_stb && !ack_ff;
    rd_hit    = nxt_ack && !i_wb_we;
    wcon      = 32'h0;
    wcon[DNC_LSB +: 5]  = dnc_ff;
    wcon[BUSY_BIT]      = busy_ff;
    wcon[STOP_IN_IDLE_BIT]     = stop_in_idle_ff;
    wcon[ON_BIT]        = on_ff;
    wcon[OPM_LSB +: 3]  = opm_ff;
    wcon[REQ_LSB +: 3]  = req_ff;
    wcfg      = cfg_ff;
    wint      = 32'h0;
    wint[IE_HI_LSB +: 5] = ien_ff[8:4];
    wint[IE_LO_LSB +: 4] = ien_ff[3:0];
    wint[IF_HI_LSB +: 5] = flg_ff[6:2];
    wint[IF_LO_LSB +: 4] = {flg_ff[1:0], i_rx_buffer_pending, i_tx_buffer_pending};
    nxt_rdat  = 32'h0;
    if (rd_hit)
    begin
      case (i_wb_adr)
        OFS_CON: nxt_rdat = wcon;
        OFS_CFG: nxt_rdat = wcfg;
        OFS_INT: nxt_rdat = wint;
        default: nxt_rdat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0;
    end
    else
    begin
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // ********************
  // Control, mode and flag registers
  // ********************
  // Flags order: invalid, wake, bus err, sys err, rx ovf, mode, timer
  always_comb
  begin
    nxt_on    = on_ff;
    nxt_stop_in_idle = stop_in_idle_ff;
    nxt_dnc   = dnc_ff;
    nxt_req   = req_ff;
    nxt_opm   = opm_ff;
    nxt_cfg   = cfg_ff;
    nxt_ien   = ien_ff;
    nxt_flg   = flg_ff;
    re_enable = 1'b0;
    // Merged write values kept apart from the read-back words
    mcon      = (wcon & ~wmask) | (i_wb_dat & wmask);
    mint      = (wint & ~wmask) | (i_wb_dat & wmask);
    if (wr && i_wb_adr == OFS_CON)
    begin
      nxt_on    = mcon[ON_BIT];
      re_enable = mcon[ON_BIT] && !on_ff;
      nxt_stop_in_idle = mcon[STOP_IN_IDLE_BIT];
      if (mcon[DNC_LSB +: 5] <= DNC_MAX)
        nxt_dnc = mcon[DNC_LSB +: 5];
      if (mcon[REQ_LSB +: 3] != 3'h5 && mcon[REQ_LSB +: 3] != 3'h6)
        nxt_req = mcon[REQ_LSB +: 3];
    end
    if (wr && i_wb_adr == OFS_CFG && opm_ff == MODE_CONFIG)
      nxt_cfg = ((cfg_ff & ~wmask) | (i_wb_dat & wmask)) & CFG_MASK;
    if (wr && i_wb_adr == OFS_INT)
    begin
      nxt_ien = {mint[IE_HI_LSB +: 5], mint[IE_LO_LSB +: 4]};
      nxt_flg = {mint[IF_HI_LSB +: 5], mint[IF_LO_LSB + 2 +: 2]};
      nxt_flg[3] = flg_ff[3];
    end
    if (re_enable)
      nxt_flg[3] = 1'b0;
    // Mode switch waits for the current transaction to finish
    if (on_ff && req_ff != opm_ff && !i_txn_active)
    begin
      nxt_opm    = req_ff;
      nxt_flg[1] = 1'b1;
    end
    // Hardware sets win over software clears
    if (i_invalid_msg)    nxt_flg[6] = 1'b1;
    if (wake_ev)          nxt_flg[5] = 1'b1;
    if (i_bus_error)      nxt_flg[4] = 1'b1;
    if (i_system_error)   nxt_flg[3] = 1'b1;
    if (i_rx_overflow)    nxt_flg[2] = 1'b1;
    if (i_timer_overflow) nxt_flg[0] = 1'b1;
    // Busy holds until enable is off and traffic has drained
    nxt_busy  = on_ff || i_txn_active;
    flags_all = {flg_ff[6:1], flg_ff[0], i_rx_buffer_pending, i_tx_buffer_pending};
    nxt_irq   = |(flags_all & ien_ff);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      on_ff    <= 1'b0;
      stop_in_idle_ff <= 1'b0;
      busy_ff  <= 1'b0;
      dnc_ff   <= 5'h0;
      req_ff   <= MODE_RESET;
      opm_ff   <= MODE_RESET;
      cfg_ff   <= 32'h0;
      ien_ff   <= 9'h0;
      flg_ff   <= 7'h0;
      irq_ff   <= 1'b0;
    end
    else
    begin
      on_ff    <= nxt_on;
      stop_in_idle_ff <= nxt_stop_in_idle;
      busy_ff  <= nxt_busy;
      dnc_ff   <= nxt_dnc;
      req_ff   <= nxt_req;
      opm_ff   <= nxt_opm;
      cfg_ff   <= nxt_cfg;
      ien_ff   <= nxt_ien;
      flg_ff   <= nxt_flg;
      irq_ff   <= nxt_irq;
    end
  end

  // ********************
  // Wake line filter
  // ********************
  // Glitches shorter than the filter time never reach wake detect
  always_comb
  begin
    nxt_fcnt = fcnt_ff;
    nxt_frx  = frx_ff;
    if (i_can_rx == frx_ff)
      nxt_fcnt = 8'h0;
    else if (fcnt_ff == 8'(FILT_CYC - 1))
    begin
      nxt_frx  = i_can_rx;
      nxt_fcnt = 8'h0;
    end
    else
      nxt_fcnt = fcnt_ff + 8'h1;
    wrx_now = cfg_ff[WFIL_BIT] ? frx_ff : i_can_rx;
    nxt_wrx = wrx_now;
    wake_ev = wrx_ff && !wrx_now && opm_ff == MODE_DISABLE;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      fcnt_ff <= 8'h0;
      frx_ff  <= 1'b1;
      wrx_ff  <= 1'b1;
    end
    else
    begin
      fcnt_ff <= nxt_fcnt;
      frx_ff  <= nxt_frx;
      wrx_ff  <= nxt_wrx;
    end
  end

  // ********************
  // Bit timing engine
  // ********************
  // Quantum divider, segment counter and edge resync
  always_comb
  begin
    run      = on_ff && !(stop_in_idle_ff && i_sys_idle)
               && opm_ff != MODE_CONFIG && opm_ff != MODE_DISABLE;
    tick     = run && pcnt_ff == {cfg_ff[BRP_LSB +: 6], 1'b1};
    nxt_pcnt = (!run || tick) ? 7'h0 : pcnt_ff + 7'h1;
    // Auto phase two: larger of phase one and processing time
    if (cfg_ff[PH2TS_BIT])
      ph2_code = cfg_ff[PH2_LSB +: 3];
    else if (cfg_ff[PH1_LSB +: 3] > IPT_CODE)
      ph2_code = cfg_ff[PH1_LSB +: 3];
    else
      ph2_code = IPT_CODE;
    prop_q = {2'b0, cfg_ff[PROP_LSB +: 3]} + 5'h1;
    ph1_q  = {2'b0, cfg_ff[PH1_LSB +: 3]} + 5'h1;
    ph2_q  = {2'b0, ph2_code} + 5'h1;
    sjw_q  = {3'b0, cfg_ff[SJW_LSB +: 2]} + 5'h1;
    sp_q   = 5'h1 + prop_q + ph1_q + {2'b0, ext_ff};
    bit_q  = sp_q + ph2_q;
    spt    = tick && q_ff == sp_q - 5'h1;
    nxt_smp = tick ? {smp_ff[1:0], i_can_rx} : smp_ff;
    // Majority of three quanta, or the current one only
    if (cfg_ff[SAM_BIT])
      sbit = (smp_ff[1] & smp_ff[0]) | (smp_ff[1] & i_can_rx) | (smp_ff[0] & i_can_rx);
    else
      sbit = i_can_rx;
    nxt_rxp = tick ? i_can_rx : rxp_ff;
    nxt_q   = q_ff;
    nxt_ext = ext_ff;
    if (!run)
    begin
      nxt_q   = 5'h0;
      nxt_ext = 3'h0;
    end
    else if (tick)
    begin
      if (q_ff >= bit_q - 5'h1)
      begin
        nxt_q   = 5'h0;
        nxt_ext = 3'h0;
      end
      else
        nxt_q = q_ff + 5'h1;
      // Falling edge outside sync: late lengthens, early shortens
      if (rxp_ff && !i_can_rx && q_ff != 5'h0)
      begin
        if (q_ff < sp_q && ext_ff == 3'h0)
          nxt_ext = (q_ff < sjw_q) ? q_ff[2:0] : sjw_q[2:0];
        else if (q_ff >= sp_q && bit_q - 5'h1 - q_ff < sjw_q)
        begin
          nxt_q   = 5'h0;
          nxt_ext = 3'h0;
        end
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      pcnt_ff <= 7'h0;
      q_ff    <= 5'h0;
      ext_ff  <= 3'h0;
      smp_ff  <= 3'h7;
      rxp_ff  <= 1'b1;
      tick_ff <= 1'b0;
      spt_ff  <= 1'b0;
      sbit_ff <= 1'b1;
      halt_ff <= 1'b0;
    end
    else
    begin
      pcnt_ff <= nxt_pcnt;
      q_ff    <= nxt_q;
      ext_ff  <= nxt_ext;
      smp_ff  <= nxt_smp;
      rxp_ff  <= nxt_rxp;
      tick_ff <= tick;
      spt_ff  <= spt;
      sbit_ff <= spt ? sbit : sbit_ff;
      halt_ff <= on_ff && stop_in_idle_ff && i_sys_idle;
    end
  end

  // Outputs straight from flops
  assign o_wb_ack             = ack_ff;
  assign o_wb_dat             = rdat_ff;
  assign o_irq                = irq_ff;
  assign o_tq_tick            = tick_ff;
  assign o_sample_point       = spt_ff;
  assign o_sample_bit         = sbit_ff;
  assign o_halted             = halt_ff;
  assign o_data_compare_count = dnc_ff;

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_idle_freeze: assert property (stop_in_idle_ff && i_sys_idle |=> !o_tq_tick)
    else $error("quantum tick while stopped in idle");
  a_busy_on: assert property (on_ff |=> busy_ff ##1 (busy_ff || !$past(on_ff)))
    else $error("busy low while enabled");
  a_dnc_valid: assert property (dnc_ff <= DNC_MAX)
    else $error("invalid compare count stored");
  a_cfg_locked: assert property (opm_ff != MODE_CONFIG |=> $stable(cfg_ff))
    else $error("timing register changed outside config");
  a_tq_period: assert property (tick |=> !tick)
    else $error("quantum shorter than two clocks");
  a_phase_two_auto: assert property (!cfg_ff[PH2TS_BIT] |-> ph2_q >= ph1_q && ph2_q >= 5'h2)
    else $error("auto phase two too short");
  a_serr_sticky: assert property (flg_ff[3] && !re_enable |=> flg_ff[3])
    else $error("system error flag cleared without re-enable");
  a_irq_follow: assert property ((|(flags_all & ien_ff)) |=> o_irq)
    else $error("interrupt not raised");
  a_irq_quiet: assert property (!(|(flags_all & ien_ff)) |=> !o_irq)
    else $error("spurious interrupt");
  a_mode_flag: assert property (opm_ff != $past(opm_ff) |-> flg_ff[1])
    else $error("mode change flag missing");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");

  c_mode_change: cover property (opm_ff == MODE_CONFIG ##1 opm_ff == MODE_NORMAL);
  c_triple_sample: cover property (cfg_ff[SAM_BIT] && spt);
  c_resync_late: cover property (ext_ff != 3'h0 && spt);
  c_sys_error: cover property (i_system_error ##1 o_irq);

endmodule : can_control_timing_irq

// [verification/can_bus_node.sv]
// Far-side bus node model driving the receive line
`timescale 1ns/10ps
module can_bus_node
#(
  parameter int DOM_CYC = 8
)
(
  input  wire logic i_clk,
  input  wire logic i_send,
  output logic      o_rx
);
  int cnt_ff = 0;
  // ********************
  // Dominant burst
  // ********************
  // One request gives one dominant burst of DOM_CYC clocks
  always_ff @(posedge i_clk)
  begin
    if (cnt_ff != 0)
      cnt_ff <= cnt_ff - 1;
    else if (i_send)
      cnt_ff <= DOM_CYC;
  end
  // Line released: the bus rests recessive, so no stale level is kept
  assign o_rx = (cnt_ff == 0);
endmodule : can_bus_node

// [verification/tb.sv]
// Self-checking bench for the CAN control, timing and interrupt block
`timescale 1ns/10ps
module tb;
  import can_ctl_pkg::*;
  logic        i_clk = 0, i_rst_n = 0, cyc = 0, stb = 0, we = 0, idle = 0, txn = 0;
  logic        rxp = 0, txp = 0, send = 0, ack, irq, tick, sp, sbit, halted, rx;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, r;
  logic [4:0]  ev = 5'h0, dcc;
  int          n_errors = 0, checks = 0, n;
  int          fb[5] = '{15, 13, 2, 11, 12};
  always #10 i_clk = ~i_clk;
  can_control_timing_irq #(.FILT_CYC(2)) can_control_timing_irq_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_can_rx(rx), .i_sys_idle(idle), .i_txn_active(txn), .i_invalid_msg(ev[0]),
    .i_bus_error(ev[1]), .i_system_error(ev[4]), .i_rx_overflow(ev[3]),
    .i_timer_overflow(ev[2]), .i_rx_buffer_pending(rxp), .i_tx_buffer_pending(txp),
    .o_irq(irq), .o_tq_tick(tick), .o_sample_point(sp), .o_sample_bit(sbit),
    .o_halted(halted), .o_data_compare_count(dcc));
  can_bus_node #(.DOM_CYC(8)) can_bus_node_i (.i_clk(i_clk), .i_send(send), .o_rx(rx));
  // ********************
  // Common tasks
  // ********************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Ack and data are taken at the rising edge that samples ack high; the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do
    begin
      @(posedge i_clk);
    end
    while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb
  task automatic wait_n(input int c);
    repeat (c) @(negedge i_clk);
  endtask : wait_n
  // Clocks between two pulses of the sample point or of the quantum tick
  task automatic gap(input bit use_sp, output int g);
    int k;
    k = 0;
    g = 0;
    while ((use_sp ? sp : tick) !== 1'b1 && k < 200)
    begin
      @(negedge i_clk);
      k++;
    end
    do
    begin
      @(negedge i_clk);
      g++;
    end
    while ((use_sp ? sp : tick) !== 1'b1 && g < 200);
  endtask : gap
  // ********************
  // Scenarios
  // ********************
  task automatic t_reset;
    wb(0, OFS_CON, 0); chk(r, 32'h0480_0000);
    wb(0, OFS_CFG, 0); chk(r, 32'h0);
    wb(0, OFS_INT, 0); chk(r, 32'h0);
    wb(0, 8'h30, 0); chk(r, 32'h0);
    $display("reset values done");
  endtask : t_reset
  task automatic t_count;
    wb(1, OFS_CON, 32'h0400_0012); wb(0, OFS_CON, 0); chk(r, 32'h0480_0012);
    chk(dcc, 5'h12);
    wb(1, OFS_CON, 32'h0400_0013); wb(0, OFS_CON, 0); chk(r, 32'h0480_0012);
    wb(1, OFS_CON, 32'h0400_0000); chk(dcc, 5'h00);
    $display("compare count done");
  endtask : t_count
  // Programmed phase two read back, then automatic phase two sets the bit length
  task automatic t_timing;
    wb(1, OFS_CFG, 32'h0002_9101); wb(0, OFS_CFG, 0); chk(r, 32'h0002_9101);
    wb(1, OFS_CFG, 32'h0000_1901);
    wb(1, OFS_CON, 32'h0000_8000); wait_n(4);
    wb(0, OFS_CON, 0); chk(r, 32'h0000_8800);
    wb(0, OFS_INT, 0); chk(r, 32'h0000_0008);
    wb(1, OFS_CFG, 32'h0002_9101);
    wb(0, OFS_CFG, 0); chk(r, 32'h0000_1901);
    gap(0, n); chk(n, 4);
    gap(1, n); gap(1, n); chk(n, 44);
    chk(sbit, 1'b1);
    $display("bit timing done");
  endtask : t_timing
  // Triple sampling and line filter on; prescaler kept at two or more
  task automatic t_triple;
    wb(1, OFS_CON, 32'h0400_8000); wait_n(4);
    wb(1, OFS_CFG, 32'h0040_5902);
    wb(0, OFS_CFG, 0); chk(r, 32'h0040_5902);
    wb(1, OFS_CON, 32'h0000_8000); wait_n(4);
    gap(0, n); chk(n, 6);
    gap(1, n); gap(1, n); chk(n, 66);
    chk(sbit, 1'b1);
    $display("triple sample done");
  endtask : t_triple
  task automatic t_idle;
    wb(1, OFS_CON, 32'h0000_a000); idle <= 1'b1; wait_n(3);
    chk(halted, 1'b1);
    wb(1, OFS_CON, 32'h0000_8000); wait_n(2);
    chk(halted, 1'b0);
    @(posedge i_clk);
    idle <= 1'b0;
    $display("stop in idle done");
  endtask : t_idle
  task automatic t_irq;
    wb(1, OFS_INT, 32'hf80f_0000); wb(0, OFS_INT, 0); chk(r, 32'hf80f_0000);
    // System error comes last, since its flag cannot be cleared here
    for (int k = 0; k < 5; k++)
    begin
      wait_n(1); chk(irq, 1'b0);
      @(posedge i_clk); ev <= 5'h1 << k;
      @(posedge i_clk); ev <= 5'h0;
      wait_n(2); chk(irq, 1'b1);
      wb(0, OFS_INT, 0);
      chk(r, 32'hf80f_0000 | (32'h1 << fb[k]));
      wb(1, OFS_INT, 32'hf80f_0000);
    end
    rxp <= 1'b1; txp <= 1'b1;
    wb(0, OFS_INT, 0); chk(r, 32'hf80f_1003);
    rxp <= 1'b0; txp <= 1'b0;
    wb(1, OFS_INT, 32'h0); wait_n(3); chk(irq, 1'b0);
    wb(0, OFS_INT, 0); chk(r, 32'h0000_1000);
    $display("interrupt flags done");
  endtask : t_irq
  // Disable while a transfer runs: busy holds until it ends
  task automatic t_busy;
    txn <= 1'b1; wb(1, OFS_CON, 32'h0); wait_n(2);
    wb(0, OFS_CON, 0); chk(r, 32'h0000_0800);
    @(posedge i_clk);
    txn <= 1'b0; wait_n(3);
    wb(0, OFS_CON, 0); chk(r, 32'h0);
    wb(1, OFS_CON, 32'h0000_8000); wb(0, OFS_INT, 0); chk(r, 32'h0);
    $display("busy status done");
  endtask : t_busy
  task automatic t_wake;
    wb(1, OFS_CON, 32'h0500_8000); wb(0, OFS_CON, 0); chk(r, 32'h0000_8800);
    wb(1, OFS_CON, 32'h0100_8000); wait_n(4);
    wb(0, OFS_CON, 0); chk(r, 32'h0120_8800);
    wb(1, OFS_INT, 32'h4000_0000);
    @(posedge i_clk); send <= 1'b1;
    @(posedge i_clk); send <= 1'b0;
    wait_n(12); chk(irq, 1'b1);
    wb(0, OFS_INT, 0); chk(r, 32'h4000_4000);
    $display("wake-up done");
  endtask : t_wake
  // ********************
  // Run control
  // ********************
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  // Tests take well under a thousand clocks; the 20000-clock limit leaves a wide margin
  initial
  begin
    #400000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_count();
    t_timing();
    t_triple();
    t_idle();
    t_irq();
    t_busy();
    t_wake();
    give_verdict();
  end
endmodule : tb
